//--- design/ldbe_pkg.sv
// Constants shared by the lane balance coder.
// Assumes a single core clock; no registers reachable by software.
// Contract
// - Balanced mode adds one balance flag bit per lane every cycle.
// - Flag is 0 for payload sent as is, 1 for inverted payload.
// - Word disparity equals count of ones minus count of zeros.
// - Running disparity starts at zero after reset and stays from +7 down to -6.
// - Add word disparity minus 1 if plain, 1 minus disparity if inverted.
// - Running disparity saturates at +7 and -6, never wraps.
// - Positive running and positive word disparity: send inverted.
// - Positive running, zero or negative word disparity: send as is.
// - Negative running, positive word disparity: send as is.
// - Negative running, zero or negative word disparity: send inverted.
// - Zero running disparity: send inverted regardless of word.
// - Unbalanced mode sends no flag, keeping legacy receiver lane format.
package ldbe_pkg;
    localparam int LDBE_LANES = 8;
    localparam int LDBE_WORD_BITS = 6;
    localparam int LDBE_DISP_W = 5;
    localparam logic signed [4:0] LDBE_DISP_MAX = 5'sh07;
    localparam logic signed [4:0] LDBE_DISP_MIN = -5'sh06;
    localparam logic signed [4:0] LDBE_DISP_RESET = 5'sh00;
endpackage

//--- design/ldbe_encoder.sv
// Per-lane DC balance coder ahead of the serializer: one lane cell, one copy per lane.
// Assumes data and mode select come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

// One lane: decides inversion, appends the flag and tracks running disparity
module ldbe_lane
    import ldbe_pkg::*;
#(
    parameter int WORD_BITS = LDBE_WORD_BITS
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic balance_mode_select,
    input wire logic [WORD_BITS-1:0] word,
    output logic [WORD_BITS:0] lane_bits,
    output logic balance_flag_bit
);

    logic signed [LDBE_DISP_W-1:0] disp_reg;
    logic signed [LDBE_DISP_W-1:0] disp_next;
    logic signed [LDBE_DISP_W-1:0] wdisp;
    // Two guard bits so the unclamped sum cannot wrap before saturation
    logic signed [LDBE_DISP_W+1:0] sum;
    logic invert;
    logic flag_reg;
    logic [WORD_BITS:0] out_reg;
    logic [WORD_BITS:0] out_next;

    // Ones minus zeros: start at minus the word width, add two per set bit
    always_comb
    begin
        wdisp = -LDBE_DISP_W'(WORD_BITS);
        for (int i = 0; i < WORD_BITS; i++)
        begin
            if (word[i])
            begin
                wdisp = wdisp + LDBE_DISP_W'(2);
            end
        end
    end

    always_comb
    begin
        if (disp_reg > 0)
        begin
            invert = (wdisp > 0);
        end
        else if (disp_reg < 0)
        begin
            invert = (wdisp <= 0);
        end
        else
        begin
            invert = 1'b1;
        end
    end

    always_comb
    begin
        if (invert)
        begin
            sum = 7'(disp_reg) + 7'sh01 - 7'(wdisp);
        end
        else
        begin
            sum = 7'(disp_reg) + 7'(wdisp) - 7'sh01;
        end
    end

    // Plain mode freezes the disparity so a return to balanced mode resumes it
    always_comb
    begin
        if (!balance_mode_select)
        begin
            disp_next = disp_reg;
        end
        else if (sum > 7'(LDBE_DISP_MAX))
        begin
            disp_next = LDBE_DISP_MAX;
        end
        else if (sum < 7'(LDBE_DISP_MIN))
        begin
            disp_next = LDBE_DISP_MIN;
        end
        else
        begin
            disp_next = sum[LDBE_DISP_W-1:0];
        end
    end

    // Plain mode keeps the legacy format: the bit above the payload stays low
    always_comb
    begin
        if (balance_mode_select)
        begin
            out_next = {invert, invert ? ~word : word};
        end
        else
        begin
            out_next = {1'b0, word};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            disp_reg <= LDBE_DISP_RESET;
        end
        else
        begin
            disp_reg <= disp_next;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_reg <= '0;
            flag_reg <= 1'b0;
        end
        else
        begin
            out_reg <= out_next;
            flag_reg <= balance_mode_select && invert;
        end
    end

    assign lane_bits = out_reg;
    assign balance_flag_bit = flag_reg;

    // Polarity checks look at the decision inputs one edge before the flag shows
    a_word_disp: assert property (@(posedge clk) disable iff (!nrst)
        wdisp == 2 * $countones(word) - WORD_BITS)
        else $error("word disparity wrong");

    a_disp_range: assert property (@(posedge clk) disable iff (!nrst)
        disp_reg <= LDBE_DISP_MAX && disp_reg >= LDBE_DISP_MIN)
        else $error("disparity out of range");

    a_zero_inverts: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg == 0 |=> flag_reg)
        else $error("zero disparity did not invert");

    a_pos_pos: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg > 0 && wdisp > 0 |=> flag_reg)
        else $error("pos pos not inverted");

    a_pos_neg: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg > 0 && wdisp <= 0 |=> !flag_reg)
        else $error("pos nonpos inverted");

    a_neg_pos: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg < 0 && wdisp > 0 |=> !flag_reg)
        else $error("neg pos inverted");

    a_neg_neg: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg < 0 && wdisp <= 0 |=> flag_reg)
        else $error("neg nonpos not inverted");

    a_flag_payload: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select |=> out_reg[WORD_BITS] == flag_reg
        && out_reg[WORD_BITS-1:0] == (flag_reg ? ~$past(word) : $past(word)))
        else $error("payload does not match flag");

    a_plain_mode: assert property (@(posedge clk) disable iff (!nrst)
        !balance_mode_select |=> !flag_reg && !out_reg[WORD_BITS]
        && out_reg[WORD_BITS-1:0] == $past(word) && $stable(disp_reg))
        else $error("plain mode altered data");

    a_disp_step: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg < 0 && wdisp == 6
        |=> disp_reg == $past(disp_reg) + 5'sh05)
        else $error("disparity update wrong");

    a_pos_drop: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg > 0 && wdisp == 6
        |=> disp_reg == $past(disp_reg) - 5'sh05)
        else $error("inverted update wrong");

    a_zero_step: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg == 0 && wdisp == 6 |=> disp_reg == -5'sh05)
        else $error("zero disparity step wrong");

    a_zero_low: assert property (@(posedge clk) disable iff (!nrst)
        balance_mode_select && disp_reg == 0 && wdisp == -6 |=> disp_reg == LDBE_DISP_MAX)
        else $error("upper limit step wrong");

    a_reset_zero: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> disp_reg == LDBE_DISP_RESET && out_reg == '0)
        else $error("reset state wrong");

endmodule

module ldbe_encoder
    import ldbe_pkg::*;
#(
    parameter int LANES = LDBE_LANES,
    parameter int WORD_BITS = LDBE_WORD_BITS
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic balance_mode_select,
    input wire logic [LANES*WORD_BITS-1:0] data_in,
    output logic [LANES*(WORD_BITS+1)-1:0] lane_out,
    output logic [LANES-1:0] balance_flag_bit
);
    // Lanes share only clock, reset and the mode select; each cell keeps its own disparity
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : gl
            ldbe_lane #(
                .WORD_BITS(WORD_BITS)
            )
            ldbe_lane_inst
            (
                .clk(clk),
                .nrst(nrst),
                .balance_mode_select(balance_mode_select),
                .word(data_in[g*WORD_BITS +: WORD_BITS]),
                .lane_bits(lane_out[g*(WORD_BITS+1) +: WORD_BITS+1]),
                .balance_flag_bit(balance_flag_bit[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

//--- tb/ldbe_rx_model.sv
// Far-end receiver model: strips the balance flag from each lane.
// Assumes the coder's lane_out on its input.
`timescale 1ns/10ps
`default_nettype none
module ldbe_rx_model
    import ldbe_pkg::*;
(
    input wire logic [55:0] lane_in,
    output logic [47:0] data_out
);
    always_comb
    begin
        for (int g = 0; g < LDBE_LANES; g++)
            data_out[g*6+:6] = lane_in[g*7+:6] ^ {6{lane_in[g*7+6]}};
    end
endmodule
`default_nettype wire

//--- tb/tb_lvds_dc_balance_encoder.sv
// Self-checking bench for the lane balance coder.
// Assumes one clock from capture to lane output.
`timescale 1ns/10ps
`default_nettype none
module tb_lvds_dc_balance_encoder;
    import ldbe_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic mode = 1'b0;
    logic [47:0] din = 48'h0;
    logic [47:0] prev_d, dd, rx_data;
    logic [55:0] lane_out, exp_lane;
    logic [7:0] flags, exp_f;
    int rd [8];
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    ldbe_encoder ldbe_encoder_inst (.clk(clk), .nrst(nrst), .balance_mode_select(mode),
        .data_in(din), .lane_out(lane_out), .balance_flag_bit(flags));
    ldbe_rx_model ldbe_rx_model_inst (.lane_in(lane_out), .data_out(rx_data));
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    begin
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task automatic finish_test();
    begin
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // Reset clears expectations too, since every lane restarts from zero
    task automatic reset_dut();
    begin
        @(posedge clk);
        nrst <= 1'b0;
        din <= 48'h0;
        mode <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(lane_out, 56'h0);
        check({48'h0, flags}, 56'h0);
        @(posedge clk);
        nrst <= 1'b1;
        rd = '{default: 0};
        exp_lane = 56'h0;
        exp_f = 8'h00;
        prev_d = 48'h0;
    end
    endtask
    task automatic step(input logic [47:0] d, input logic m);
        int wd;
        logic inv;
    begin
        @(posedge clk);
        din <= d;
        mode <= m;
        #1;
        check(lane_out, exp_lane);
        check({48'h0, flags}, {48'h0, exp_f});
        check({8'h0, rx_data}, {8'h0, prev_d});
        for (int g = 0; g < 8; g++)
        begin
            wd = 2 * $countones(d[g*6+:6]) - 6;
            inv = m && (rd[g] == 0 || ((rd[g] > 0) == (wd > 0)));
            exp_lane[g*7+:7] = {inv, d[g*6+:6] ^ {6{inv}}};
            exp_f[g] = inv;
            if (m)
                rd[g] = rd[g] + (inv ? 1 - wd : wd - 1);
            rd[g] = rd[g] > 7 ? 7 : (rd[g] < -6 ? -6 : rd[g]);
        end
        prev_d = d;
    end
    endtask
    initial
    begin
        #5000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        reset_dut();
        repeat (3) step({8{6'h3F}}, 1'b1);
        for (int i = 0; i < 64; i++)
        begin
            for (int g = 0; g < 8; g++)
                dd[g*6+:6] = 6'(i * (g + 1) + g);
            step(dd, (i % 5) != 0);
        end
        reset_dut();
        repeat (2) step({8{6'h3F}}, 1'b1);
        step(48'h0, 1'b1);
        step({8{6'h3F}}, 1'b1);
        step(48'h0, 1'b0);
        step(48'h0, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
